// File: hdl/ffx_fifo.sv
// fifo device with sampled write/read clocks, flags and axi-lite setup
//
// Added by the designer: register access over AXI4-Lite and the address map.
module ffx_fifo #(
	parameter int DEPTH = ffx_pkg::FFX_DEPTH_DEF,
	parameter int DW = ffx_pkg::FFX_DATA_W_DEF
) (
	// system
	input wire logic clk_in,
	input wire logic resetn_in,
	// write side pins
	input wire logic wclk_in,
	input wire logic wen_n_in,
	input wire logic [DW-1:0] din_in,
	// read side pins
	input wire logic rclk_in,
	input wire logic ren_n_in,
	output logic [DW-1:0] dout_out,
	// flags
	output logic empty_or_valid_n_out,
	output logic full_or_room_n_out,
	output logic almost_full_n_out,
	output logic almost_empty_n_out,
	output logic half_full_n_out,
	// axi4-lite write
	input wire logic [3:0] awaddr_in,
	input wire logic [2:0] awprot_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	// axi4-lite read
	input wire logic [3:0] araddr_in,
	input wire logic [2:0] arprot_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in
);
	import ffx_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	typedef struct packed {
		logic [3:0] wck;
		logic [3:0] rck;
		logic [1:0] wen;
		logic [1:0] ren;
		logic [1:0][DW-1:0] din;
		logic pf;
		logic [CW-1:0] cnt;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic ov;
		logic [DW-1:0] dout;
		logic eo_n;
		logic fr_n;
		logic af_n;
		logic ae_n;
		logic hf_n;
		logic pf_sel;
		logic [CW-1:0] eofs;
		logic [CW-1:0] fofs;
		logic master_reset_n;
		logic awv;
		logic [3:0] awa;
		logic wv;
		logic [31:0] wd;
		logic [3:0] ws;
		logic awrdy;
		logic wrdy;
		logic bv;
		logic [1:0] br;
		logic arrdy;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} ffx_st_t;

	ffx_st_t st_r, st_nxt;
	logic [DW-1:0] mem [DEPTH];

	logic we_edge, re_edge, do_wr, pop, drop;
	logic [CW-1:0] cnt_n, occ_n, deff, half, af_thr, ae_thr;
	logic [31:0] reg_w, stat_v;

	//------------------------------------------------------------
	// storage
	//------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem[st_r.wp] <= st_r.din[1];
		end
	end

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// pin sync: first stage feeds only the second
		st_nxt.wck = {st_r.wck[2:0], wclk_in};
		st_nxt.rck = {st_r.rck[2:0], rclk_in};
		st_nxt.wen = {st_r.wen[0], wen_n_in};
		st_nxt.ren = {st_r.ren[0], ren_n_in};
		st_nxt.din = {st_r.din[0], din_in};
		// clock edge seen one cycle later than the data stage, so data sampled with it is from after the edge
		we_edge = st_r.wck[2] & ~st_r.wck[3];
		re_edge = st_r.rck[2] & ~st_r.rck[3];

		// output register counts as one more word in prefetch
		deff = CW'(DEPTH) + CW'(st_r.pf);
		half = deff >> 1;
		af_thr = deff - st_r.fofs;
		ae_thr = st_r.eofs + CW'(st_r.pf);

		// writes refused while the stored count is at DEPTH; the room flag is not consulted
		do_wr = we_edge & ~st_r.wen[1] & (st_r.cnt < CW'(DEPTH));
		if (st_r.pf) begin
			// prefetch refills the output register without a read
			pop = re_edge & (st_r.cnt != '0) & (~st_r.ov | ~st_r.ren[1]);
			drop = re_edge & st_r.ov & ~st_r.ren[1] & (st_r.cnt == '0);
		end else begin
			pop = re_edge & ~st_r.ren[1] & (st_r.cnt != '0);
			drop = 1'b0;
		end
		cnt_n = st_r.cnt + CW'(do_wr) - CW'(pop);
		if (do_wr) begin
			st_nxt.wp = st_r.wp + AW'(1);
		end
		if (pop) begin
			st_nxt.rp = st_r.rp + AW'(1);
			st_nxt.dout = mem[st_r.rp];
		end
		if (st_r.pf) begin
			// valid and data change together; feeds next device's write
			st_nxt.ov = pop | (st_r.ov & ~drop);
		end
		st_nxt.cnt = cnt_n;
		occ_n = cnt_n + CW'(st_nxt.ov);

		// write-side flags move on write edges only
		if (we_edge) begin
			st_nxt.af_n = ~(occ_n >= af_thr);
			if (st_r.pf) begin
				// freed slot shows as room on the next write edge
				st_nxt.fr_n = occ_n >= deff;
			end else begin
				st_nxt.fr_n = occ_n < deff;
			end
		end
		// read-side flags move on read edges only
		if (re_edge) begin
			st_nxt.ae_n = ~(occ_n <= ae_thr);
			if (st_r.pf) begin
				st_nxt.eo_n = ~st_nxt.ov;
			end else begin
				st_nxt.eo_n = occ_n != '0;
			end
		end
		// half full: set by write edge, cleared by read edge
		if (we_edge && occ_n > half) begin
			st_nxt.hf_n = 1'b0;
		end else if (re_edge && occ_n <= half) begin
			st_nxt.hf_n = 1'b1;
		end

		//--------------------------------------------------------
		// axi4-lite write channel
		//--------------------------------------------------------
		if (awvalid_in && st_r.awrdy) begin
			st_nxt.awv = 1'b1;
			st_nxt.awa = awaddr_in;
		end
		if (wvalid_in && st_r.wrdy) begin
			st_nxt.wv = 1'b1;
			st_nxt.wd = wdata_in;
			st_nxt.ws = wstrb_in;
		end
		st_nxt.master_reset_n = 1'b0;
		reg_w = '0;
		case (st_r.awa)
			FFX_EOFS_OFS: reg_w = 32'(st_r.eofs);
			FFX_FOFS_OFS: reg_w = 32'(st_r.fofs);
			FFX_CTRL_OFS: reg_w = 32'(st_r.pf_sel);
			default: reg_w = '0;
		endcase
		for (int b = 0; b < 4; b++) begin
			if (st_r.ws[b]) begin
				reg_w[8*b +: 8] = st_r.wd[8*b +: 8];
			end
		end
		if (st_r.awv && st_r.wv && !st_r.bv) begin
			st_nxt.awv = 1'b0;
			st_nxt.wv = 1'b0;
			st_nxt.bv = 1'b1;
			st_nxt.br = FFX_RESP_OK;
			case (st_r.awa)
				FFX_CTRL_OFS: begin
					st_nxt.pf_sel = reg_w[FFX_CTRL_PF_BIT];
					st_nxt.master_reset_n = reg_w[FFX_CTRL_MRS_BIT];
				end
				FFX_EOFS_OFS: st_nxt.eofs = reg_w[CW-1:0];
				FFX_FOFS_OFS: st_nxt.fofs = reg_w[CW-1:0];
				FFX_STAT_OFS: st_nxt.br = FFX_RESP_OK;
				default: st_nxt.br = FFX_RESP_ERR;
			endcase
		end
		if (st_r.bv && bready_in) begin
			st_nxt.bv = 1'b0;
		end
		st_nxt.awrdy = ~st_nxt.awv;
		st_nxt.wrdy = ~st_nxt.wv;

		//--------------------------------------------------------
		// axi4-lite read channel
		//--------------------------------------------------------
		stat_v = '0;
		stat_v[CW-1:0] = st_r.cnt + CW'(st_r.ov);
		stat_v[FFX_STAT_FLAG_POS +: 5] = {st_r.hf_n, st_r.ae_n, st_r.af_n,
			st_r.fr_n, st_r.eo_n};
		stat_v[FFX_STAT_PF_POS] = st_r.pf;
		if (arvalid_in && st_r.arrdy) begin
			st_nxt.rv = 1'b1;
			st_nxt.arrdy = 1'b0;
			st_nxt.rr = FFX_RESP_OK;
			case (araddr_in)
				FFX_CTRL_OFS: st_nxt.rd = 32'(st_r.pf_sel);
				FFX_EOFS_OFS: st_nxt.rd = 32'(st_r.eofs);
				FFX_FOFS_OFS: st_nxt.rd = 32'(st_r.fofs);
				FFX_STAT_OFS: st_nxt.rd = stat_v;
				default: begin
					st_nxt.rd = '0;
					st_nxt.rr = FFX_RESP_ERR;
				end
			endcase
		end
		if (st_r.rv && rready_in) begin
			st_nxt.rv = 1'b0;
			st_nxt.arrdy = 1'b1;
		end

		//--------------------------------------------------------
		// master reset: mode is latched only here
		//--------------------------------------------------------
		if (st_r.master_reset_n) begin
			st_nxt.pf = st_r.pf_sel;
			st_nxt.cnt = '0;
			st_nxt.wp = '0;
			st_nxt.rp = '0;
			st_nxt.ov = 1'b0;
			st_nxt.dout = '0;
			st_nxt.eo_n = st_r.pf_sel;
			st_nxt.fr_n = ~st_r.pf_sel;
			st_nxt.af_n = 1'b1;
			st_nxt.ae_n = 1'b0;
			st_nxt.hf_n = 1'b1;
		end
	end

	//------------------------------------------------------------
	// register
	//------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			st_r <= '0;
			st_r.pf <= FFX_PF_RST;
			st_r.pf_sel <= FFX_PF_RST;
			st_r.eofs <= FFX_OFS_RST[CW-1:0];
			st_r.fofs <= FFX_OFS_RST[CW-1:0];
			st_r.fr_n <= 1'b1;
			st_r.af_n <= 1'b1;
			st_r.hf_n <= 1'b1;
			st_r.awrdy <= 1'b1;
			st_r.wrdy <= 1'b1;
			st_r.arrdy <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout_out = st_r.dout;
	assign empty_or_valid_n_out = st_r.eo_n;
	assign full_or_room_n_out = st_r.fr_n;
	assign almost_full_n_out = st_r.af_n;
	assign almost_empty_n_out = st_r.ae_n;
	assign half_full_n_out = st_r.hf_n;
	assign awready_out = st_r.awrdy;
	assign wready_out = st_r.wrdy;
	assign bvalid_out = st_r.bv;
	assign bresp_out = st_r.br;
	assign arready_out = st_r.arrdy;
	assign rvalid_out = st_r.rv;
	assign rdata_out = st_r.rd;
	assign rresp_out = st_r.rr;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	chk_af_wr_only: assert property (
		(!$stable(st_r.af_n) && !$past(st_r.master_reset_n)) |-> $past(we_edge))
		else $error("almost full moved without write edge");
	chk_af_release: assert property (
		(we_edge && !st_r.master_reset_n && occ_n < af_thr) |=> almost_full_n_out)
		else $error("almost full not released");
	chk_ae_rd_only: assert property (
		(!$stable(st_r.ae_n) && !$past(st_r.master_reset_n)) |-> $past(re_edge))
		else $error("almost empty moved without read edge");
	chk_ae_thresh: assert property (
		(re_edge && !st_r.master_reset_n && st_r.pf && occ_n <= st_r.eofs + CW'(1))
		|=> !almost_empty_n_out)
		else $error("prefetch almost empty threshold wrong");
	chk_depth_bound: assert property (
		(st_r.cnt + CW'(st_r.ov)) <= CW'(DEPTH) + CW'(st_r.pf))
		else $error("occupancy beyond depth");
	chk_valid_data: assert property (
		(st_r.pf && pop && !st_r.master_reset_n) |=> (!empty_or_valid_n_out
		&& dout_out == $past(mem[st_r.rp])))
		else $error("valid not with new data");
	chk_ripple_down: assert property (
		(st_r.pf && !st_r.ov && st_r.cnt != '0 && !st_r.master_reset_n && re_edge)
		|=> (st_r.ov && !empty_or_valid_n_out))
		else $error("word did not fall through");
	chk_room_show: assert property (
		(st_r.pf && we_edge && !st_r.master_reset_n && occ_n < deff) |=> !full_or_room_n_out)
		else $error("room not shown");
	chk_hf_set: assert property (
		$fell(half_full_n_out) |-> $past(we_edge))
		else $error("half full set without write edge");

	cov_full: cover property (we_edge && occ_n == deff);
	cov_fall_through: cover property (st_r.pf && $rose(st_r.ov));
	cov_half: cover property ($fell(half_full_n_out));
	cov_bad_addr: cover property (bvalid_out && bresp_out == FFX_RESP_ERR);
endmodule // ffx_fifo

// File: hdl/ffx_pkg.sv
// constants for the dual-clock fifo flag and chaining block
//------------------------------------------------------------
//------------------------------------------------------------
package ffx_pkg;
	// register byte offsets
	localparam logic [3:0] FFX_CTRL_OFS = 4'h0;
	localparam logic [3:0] FFX_EOFS_OFS = 4'h4;
	localparam logic [3:0] FFX_FOFS_OFS = 4'h8;
	localparam logic [3:0] FFX_STAT_OFS = 4'hC;
	// control bits
	localparam int FFX_CTRL_PF_BIT = 0;
	localparam int FFX_CTRL_MRS_BIT = 1;
	// status field positions
	localparam int FFX_STAT_FLAG_POS = 24;
	localparam int FFX_STAT_PF_POS = 31;
	// reset values
	localparam logic [31:0] FFX_OFS_RST = 32'h0000_007F;
	localparam logic FFX_PF_RST = 1'b0;
	// documented depth and width
	localparam int FFX_DEPTH_DEF = 32768;
	localparam int FFX_DATA_W_DEF = 18;
	// axi responses
	localparam logic [1:0] FFX_RESP_OK = 2'h0;
	localparam logic [1:0] FFX_RESP_ERR = 2'h2;
endpackage // ffx_pkg

// File: tb/ffx_host_model.sv
// pin-side writer and reader model with free-running pin clocks
module ffx_host_model (
	// pin clocks
	output logic wclk_out,
	output logic rclk_out,
	// write side: controls of one device, one half of a 36-bit bus
	output logic wen_n_out,
	output logic [17:0] din_out,
	// read side
	output logic ren_n_out,
	input wire logic valid_n_in,
	input wire logic [17:0] dout_in
);
	timeunit 1ns;
	timeprecision 1ps;
	//----------------------------------------
	// clocks: read edges offset from write edges, read clock free-running
	// equal periods, so no extra skew cycles to budget
	//----------------------------------------
	initial begin
		wclk_out = 1'b0;
		forever #62.5 wclk_out = ~wclk_out;
	end
	initial begin
		rclk_out = 1'b0;
		#31;
		forever #62.5 rclk_out = ~rclk_out;
	end
	initial begin
		wen_n_out = 1'b1;
		ren_n_out = 1'b1;
		din_out = 18'h0_0000;
	end
	//----------------------------------------
	// transfers: one word per two pin clock periods
	//----------------------------------------
	task automatic push(input logic [17:0] d);
		@(negedge wclk_out);
		wen_n_out <= 1'b0;
		din_out <= d;
		@(negedge wclk_out);
		wen_n_out <= 1'b1;
		// idle bus must not keep the old word
		din_out <= ~d;
	endtask
	// prefetch shows the word before the read edge consumes it
	// valid taken from this device alone, never wire-tied
	task automatic pop(input logic pf, output logic [17:0] d);
		int n;
		n = 0;
		while (pf && valid_n_in !== 1'b0 && n < 400) begin
			@(negedge rclk_out);
			n++;
		end
		if (pf)
			d = dout_in;
		@(negedge rclk_out);
		ren_n_out <= 1'b0;
		@(negedge rclk_out);
		ren_n_out <= 1'b1;
		if (!pf)
			d = dout_in;
	endtask
endmodule // ffx_host_model

// File: tb/tb.sv
// self-checking bench for fifo flags, depth and register access
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ffx_pkg::*;
	localparam int DEP = 16;
	logic clk_in, resetn_in, wclk, rclk, wen_n, ren_n, evn, frn, afn, aen, hfn;
	logic [17:0] din, dout, d;
	logic [3:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, r;
	int n_errors = 0;
	int checks = 0;
	ffx_fifo #(.DEPTH(DEP), .DW(18)) dut_u (
		.clk_in(clk_in), .resetn_in(resetn_in), .wclk_in(wclk), .wen_n_in(wen_n),
		.din_in(din), .rclk_in(rclk), .ren_n_in(ren_n), .dout_out(dout),
		.empty_or_valid_n_out(evn), .full_or_room_n_out(frn), .almost_full_n_out(afn),
		.almost_empty_n_out(aen), .half_full_n_out(hfn), .awaddr_in(awaddr),
		.awprot_in(3'h0), .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
		.wstrb_in(4'hF), .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
		.bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arprot_in(3'h0),
		.arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
		.rvalid_out(rvalid), .rready_in(rready));
	ffx_host_model host_u (.wclk_out(wclk), .rclk_out(rclk), .wen_n_out(wen_n),
		.din_out(din), .ren_n_out(ren_n), .valid_n_in(evn), .dout_in(dout));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	//----------------------------------------
	// shared tasks
	//----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] dt);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		// let an edge pass so back-to-back calls never drive bready twice at once
		@(posedge clk_in);
		awaddr <= a;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk_in);
			aw = aw | (awvalid & awready);
			w = w | (wvalid & wready);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end
		do @(posedge clk_in); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_in); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_in); while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// f = {mode, half, almost empty, almost full, full or room, empty or valid}
	task automatic stat(input int occ, input logic [5:0] f);
		// flags move only on free-running pin edges, so let two periods pass
		repeat (40) @(posedge clk_in);
		axr(FFX_STAT_OFS);
		chk("status", {f[5], 2'b00, f[4:0], 8'h00, occ[15:0]}, v & 32'h9F00_FFFF);
		chk("flag pins", 32'(f[4:0]), 32'({hfn, aen, afn, frn, evn}));
	endtask
	//----------------------------------------
	// scenarios
	//----------------------------------------
	task automatic t_regs();
		axr(FFX_EOFS_OFS);
		// offset register keeps only the count-width bits of the reset value
		chk("eofs reset", FFX_OFS_RST & ((32'h1 << ($clog2(DEP) + 1)) - 32'h1), v);
		axr(FFX_CTRL_OFS);
		chk("ctrl reset", 32'h0, v);
		axr(4'h2);
		chk("rd unmapped", {30'h0, FFX_RESP_ERR}, {30'h0, r});
		axw(4'h2, 32'h1);
		chk("wr unmapped", {30'h0, FFX_RESP_ERR}, {30'h0, r});
		axw(FFX_EOFS_OFS, 32'h2);
		axw(FFX_FOFS_OFS, 32'h3);
		axr(FFX_FOFS_OFS);
		chk("fofs", 32'h3, v);
		stat(0, 6'b010110);
	endtask
	// one write past full must be dropped
	task automatic t_std();
		for (int i = 0; i <= DEP; i++)
			host_u.push(18'h2A500 + 18'(i));
		stat(DEP, 6'b001001);
		for (int i = 0; i < DEP; i++) begin
			host_u.pop(1'b0, d);
			chk("std data", 32'(18'h2A500 + 18'(i)), 32'(d));
			if (i == 3)
				stat(12, 6'b001111);
			if (i == 7)
				stat(8, 6'b011111);
			if (i == 13)
				stat(2, 6'b010111);
		end
		stat(0, 6'b010110);
	endtask
	task automatic t_pf();
		axw(FFX_CTRL_OFS, 32'h1);
		axw(FFX_CTRL_OFS, 32'h3);
		axr(FFX_CTRL_OFS);
		chk("ctrl prefetch", 32'h1, v);
		axw(FFX_EOFS_OFS, 32'h2);
		axw(FFX_FOFS_OFS, 32'h3);
		stat(0, 6'b110101);
		host_u.push(18'h15A00);
		repeat (100) @(posedge clk_in);
		chk("valid", 32'h0, {31'h0, evn});
		chk("first word", 32'h15A00, 32'(dout));
		for (int i = 1; i <= DEP + 1; i++)
			host_u.push(18'h15A00 + 18'(i));
		stat(DEP + 1, 6'b101010);
		for (int i = 0; i <= DEP; i++) begin
			host_u.pop(1'b1, d);
			chk("pf data", 32'(18'h15A00 + 18'(i)), 32'(d));
			if (i == 0)
				stat(DEP, 6'b101000);
			if (i == 12)
				stat(4, 6'b111100);
			if (i == 13)
				stat(3, 6'b110100);
		end
		stat(0, 6'b110101);
	endtask
	//----------------------------------------
	// main sequence and watchdog
	//----------------------------------------
	initial begin
		resetn_in = 1'b0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (12) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		t_regs();
		t_std();
		t_pf();
		final_report();
	end
	initial begin
		#300us;
		n_errors++;
		final_report();
	end
endmodule // tb
